// ===== logic/mts_params.svh
// Purpose: offsets, field positions, reset values and symbol counts of the task sequencer
// Assumes: included by the sequencer module only
// Notes:   counts are in received symbols or buffer bytes, not clock cycles
`ifndef MTS_PARAMS_SVH
`define MTS_PARAMS_SVH

// register byte addresses
`define MTS_OFF_CMD      4'h0
`define MTS_OFF_DATA     4'h4
`define MTS_OFF_STAT     4'h8
`define MTS_OFF_MODE     4'hC

// command byte fields
`define MTS_CMD_CRC_ZERO 5
`define MTS_CMD_LEVEL    6
`define MTS_CMD_TIMING   7

// mode register fields and reset value
`define MTS_MODE_TX      0
`define MTS_MODE_PIN_EN  1
`define MTS_MODE_SS_IEN  2
`define MTS_MODE_TOL_LO  3
`define MTS_MODE_RESET   5'h00

// buffer and symbol counts
`define MTS_BUF_LEN      4'hC
`define MTS_BUF_LAST     4'hB
`define MTS_SYNC_LAST    5'h17
`define MTS_ID_LAST      7'h15
`define MTS_BLK_S1       7'h16
`define MTS_BLK_S2       7'h2D
`define MTS_BLK_LAST     7'h44
`define MTS_FOUR_LAST    7'h03
`define MTS_SYNC_PATTERN 48'h223749F25B1B

// bytes taken by each transmit task
`define MTS_LEN_RAW      4'h6
`define MTS_LEN_HEADER   4'hA
`define MTS_LEN_MIDDLE   4'hC
`define MTS_LEN_FINAL    4'h8
`define MTS_LEN_FOUR     4'h1
`define MTS_LEN_STATION  4'h3

`endif

// ===== logic/mts_pkg.sv
// Purpose: types shared by the task sequencer and its bench
// Assumes: AXI4-Lite with 32-bit address and data
// Notes:   numeric constants live in mts_params.svh
package mts_pkg;

	typedef logic [7:0] mts_byte_t;

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_TX_MOVE = 3'b001,
		ST_HUNT    = 3'b010,
		ST_HUNT_S  = 3'b011,
		ST_ID      = 3'b100,
		ST_ID_S    = 3'b101,
		ST_BLOCK   = 3'b110,
		ST_FOUR    = 3'b111
	} mts_state_e;

	// task codes in receive mode
	typedef enum logic [2:0] {
		RX_NOP             = 3'b000,
		RX_PREAMBLE_HUNT   = 3'b001,
		RX_HEADER_READ     = 3'b010,
		RX_BODY_BLOCK_READ = 3'b011,
		RX_SYNC_HUNT       = 3'b100,
		RX_FOUR_SYMBOL     = 3'b101,
		RX_STATION_ID_READ = 3'b110,
		RX_CANCEL          = 3'b111
	} mts_rx_task_e;

	// task codes in transmit mode
	typedef enum logic [2:0] {
		TX_NOP              = 3'b000,
		TX_RAW_BLOCK_SEND   = 3'b001,
		TX_HEADER_SEND      = 3'b010,
		TX_MIDDLE_BLOCK     = 3'b011,
		TX_FINAL_BLOCK      = 3'b100,
		TX_FOUR_SYMBOL_SEND = 3'b101,
		TX_STATION_ID_SEND  = 3'b110,
		TX_CANCEL           = 3'b111
	} mts_tx_task_e;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} mts_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} mts_axi_rsp_s;

	// one received symbol per valid cycle
	typedef struct packed {
		logic       valid;
		logic [1:0] value;
	} mts_sym_s;

	// decoded bytes and checksum verdict from the decoder
	typedef struct packed {
		logic      valid;
		mts_byte_t data;
		logic      check_ok;
	} mts_dec_s;

	// byte stream towards the interleave buffer
	typedef struct packed {
		logic      valid;
		mts_byte_t data;
	} mts_tx_s;

endpackage

// ===== logic/mts_sequencer.sv
// Purpose: task sequencer of a 4-level FSK packet modem behind an AXI4-Lite slave
// Assumes: symbol and decoder streams come from logic on the same clock
// Notes:   FEC, interleave and checksum arithmetic sit outside; this block sequences them
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "mts_params.svh"

module mts_sequencer (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	// register bus
	input  wire mts_pkg::mts_axi_req_s axi_req,
	output mts_pkg::mts_axi_rsp_s      axi_rsp,
	// receive side
	input  wire mts_pkg::mts_sym_s     rx_sym,
	input  wire mts_pkg::mts_dec_s     rx_dec,
	// transmit side
	output mts_pkg::mts_tx_s           tx_out,
	input  wire logic                  tx_ready,
	// pins and controls
	output logic                       attention_out_n,
	output logic                       crc_init_ones,
	output logic                       symbol_timing_acquire,
	output logic                       level_acquire,
	output logic                       acquire_abort
);
	import mts_pkg::*;

	// saturating buffer pointer step
	function automatic logic [3:0] ptr_inc(input logic [3:0] p);
		ptr_inc = (p == `MTS_BUF_LAST) ? p : p + 4'h1;
	endfunction

	// symbols of the window that differ from the sync pattern
	function automatic logic [4:0] sync_errs(input logic [47:0] w);
		logic [47:0] pat;
		logic [4:0]  n;
		pat = `MTS_SYNC_PATTERN;
		n = 5'h00;
		for (int i = 0; i < 24; i++)
		begin
			if (w[2*i +: 2] != pat[2*i +: 2])
				n = n + 5'h01;
		end
		sync_errs = n;
	endfunction

	// bytes a transmit task takes from the buffer
	function automatic logic [3:0] tx_len(input mts_tx_task_e t);
		unique case (t)
			TX_RAW_BLOCK_SEND:   tx_len = `MTS_LEN_RAW;
			TX_HEADER_SEND:      tx_len = `MTS_LEN_HEADER;
			TX_MIDDLE_BLOCK:     tx_len = `MTS_LEN_MIDDLE;
			TX_FINAL_BLOCK:      tx_len = `MTS_LEN_FINAL;
			TX_FOUR_SYMBOL_SEND: tx_len = `MTS_LEN_FOUR;
			TX_STATION_ID_SEND:  tx_len = `MTS_LEN_STATION;
			default:             tx_len = 4'h0;
		endcase
	endfunction

	mts_axi_rsp_s rsp_q;
	mts_tx_s      tx_q;
	mts_state_e   st_q;
	mts_rx_task_e task_q;
	mts_byte_t    buf_q [`MTS_BUF_LEN];
	logic [4:0]   mode_q;
	logic [47:0]  win_q;
	logic [4:0]   fill_q;
	logic [6:0]   sym_cnt_q;
	logic [3:0]   n_bytes_q, move_q, wr_ptr_q, rd_ptr_q, dec_ptr_q;
	logic [7:0]   four_q;
	logic         avail_q, irq_q, sym_rdy_q, crc_fail_q, crc_bad_q;
	logic [1:0]   status_symbol_value_q;
	logic         attn_n_q, crc_ones_q, acq_t_q, acq_l_q, abort_q;

	// bus decode: one access of each kind at a time, ready one cycle after valid
	wire        aw_go    = axi_req.awvalid && axi_req.wvalid && !rsp_q.awready && !rsp_q.bvalid;
	wire        ar_go    = axi_req.arvalid && !rsp_q.arready && !rsp_q.rvalid;
	wire        wr_fire  = rsp_q.awready;
	wire        rd_fire  = rsp_q.arready;
	wire        wr_map   = axi_req.awaddr[31:4] == 28'h0 && axi_req.awaddr[1:0] == 2'h0;
	wire        rd_map   = axi_req.araddr[31:4] == 28'h0 && axi_req.araddr[1:0] == 2'h0;
	wire [3:0]  wr_off   = axi_req.awaddr[3:0];
	wire [3:0]  rd_off   = axi_req.araddr[3:0];
	wire        wr_lane  = wr_fire && wr_map && axi_req.wstrb[0];
	wire        cmd_fire = wr_lane && wr_off == `MTS_OFF_CMD;
	wire        dat_wr   = wr_lane && wr_off == `MTS_OFF_DATA;
	wire        mode_wr  = wr_lane && wr_off == `MTS_OFF_MODE;
	wire        dat_rd   = rd_fire && rd_map && rd_off == `MTS_OFF_DATA;
	wire        stat_rd  = rd_fire && rd_map && rd_off == `MTS_OFF_STAT;
	wire [2:0]  cmd_code = axi_req.wdata[2:0];
	wire        cmd_abort = cmd_fire && cmd_code == RX_CANCEL;
	wire        cmd_task = cmd_fire && cmd_code != RX_NOP && cmd_code != RX_CANCEL;
	wire        in_tx    = mode_q[`MTS_MODE_TX];
	wire        ss_ien   = mode_q[`MTS_MODE_SS_IEN];
	wire [1:0]  tol      = mode_q[`MTS_MODE_TOL_LO +: 2];
	wire [7:0]  stat_b   = {2'b00, status_symbol_value_q, crc_fail_q, sym_rdy_q, irq_q, avail_q};
	wire [7:0]  rd_byte  = (rd_off == `MTS_OFF_DATA) ? buf_q[rd_ptr_q] :
	                       (rd_off == `MTS_OFF_STAT) ? stat_b :
	                       (rd_off == `MTS_OFF_MODE) ? {3'b000, mode_q} : 8'h00;

	// receive-side events; a cancel write in the same cycle suppresses them
	wire        sym_in    = rx_sym.valid && !cmd_abort;
	wire [47:0] win_d     = {win_q[45:0], rx_sym.value};
	wire        sync_hit  = st_q == ST_HUNT && sym_in && fill_q == `MTS_SYNC_LAST
	                        && sync_errs(win_d) <= {3'b000, tol};
	wire        id_last   = st_q == ST_ID && sym_in && sym_cnt_q == `MTS_ID_LAST;
	wire        hunt_s    = st_q == ST_HUNT_S && sym_in;
	wire        id_s      = st_q == ST_ID_S && sym_in;
	wire        blk_s     = st_q == ST_BLOCK && sym_in && (sym_cnt_q == `MTS_BLK_S1
	                        || sym_cnt_q == `MTS_BLK_S2 || sym_cnt_q == `MTS_BLK_LAST);
	wire        blk_end   = blk_s && sym_cnt_q == `MTS_BLK_LAST;
	wire        four_end  = st_q == ST_FOUR && sym_in && sym_cnt_q == `MTS_FOUR_LAST;
	wire        id_bad    = id_last && !rx_dec.check_ok && task_q == RX_PREAMBLE_HUNT;
	// transmit-side move: next byte loads whenever the slot is free or being taken
	wire        tx_take   = tx_q.valid && tx_ready;
	wire        tx_load   = st_q == ST_TX_MOVE && (!tx_q.valid || tx_ready)
	                        && move_q != n_bytes_q;
	wire        tx_fin    = st_q == ST_TX_MOVE && tx_take && move_q == n_bytes_q
	                        && !cmd_abort;
	wire        ev_status_symbol_value   = hunt_s || id_s || blk_s;
	wire        ev_done   = tx_fin || (hunt_s && task_q == RX_SYNC_HUNT) || id_s
	                        || blk_end || four_end;

	// bus slave handshakes; unmapped addresses answer with a slave error
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rsp_q <= '0;
		else
		begin
			rsp_q.awready <= aw_go;
			rsp_q.wready  <= aw_go;
			rsp_q.arready <= ar_go;
			if (wr_fire)
			begin
				rsp_q.bvalid <= 1'b1;
				rsp_q.bresp  <= wr_map ? 2'b00 : 2'b10;
			end
			else if (axi_req.bready)
				rsp_q.bvalid <= 1'b0;
			if (rd_fire)
			begin
				rsp_q.rvalid <= 1'b1;
				rsp_q.rdata  <= {24'h000000, rd_map ? rd_byte : 8'h00};
				rsp_q.rresp  <= rd_map ? 2'b00 : 2'b10;
			end
			else if (axi_req.rready)
				rsp_q.rvalid <= 1'b0;
		end
	end

	// mode register and command side bits
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_q     <= `MTS_MODE_RESET;
			crc_ones_q <= 1'b0;
			acq_t_q    <= 1'b0;
			acq_l_q    <= 1'b0;
			abort_q    <= 1'b0;
		end
		else
		begin
			if (mode_wr)
				mode_q <= axi_req.wdata[4:0];
			if (cmd_fire)
				crc_ones_q <= !axi_req.wdata[`MTS_CMD_CRC_ZERO];
			// acquisition is a receive-mode request, also carried by a no-op byte
			acq_t_q <= cmd_fire && !in_tx && !cmd_abort
			           && axi_req.wdata[`MTS_CMD_TIMING];
			acq_l_q <= cmd_fire && !in_tx && !cmd_abort
			           && axi_req.wdata[`MTS_CMD_LEVEL];
			abort_q <= cmd_abort;
		end
	end

	// status flags: a status read clears attention and ready, a set in that cycle wins
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			avail_q    <= 1'b1;
			irq_q      <= 1'b0;
			sym_rdy_q  <= 1'b0;
			crc_fail_q <= 1'b0;
			status_symbol_value_q     <= 2'b00;
		end
		else
		begin
			if (stat_rd)
			begin
				irq_q     <= 1'b0;
				sym_rdy_q <= 1'b0;
			end
			if (cmd_task)
				avail_q <= 1'b0;
			if (cmd_abort)
				avail_q <= 1'b1;
			if (ev_status_symbol_value)
			begin
				status_symbol_value_q    <= rx_sym.value;
				sym_rdy_q <= 1'b1;
				if (ss_ien)
					irq_q <= 1'b1;
			end
			if (ev_done)
			begin
				avail_q <= 1'b1;
				irq_q   <= 1'b1;
			end
			if (blk_end)
				crc_fail_q <= !rx_dec.check_ok;
			if (id_s)
				crc_fail_q <= crc_bad_q;
		end
	end

	// sequencer state; the mode is sampled when a task is accepted
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q      <= ST_IDLE;
			task_q    <= RX_NOP;
			n_bytes_q <= 4'h0;
			sym_cnt_q <= 7'h00;
			fill_q    <= 5'h00;
			win_q     <= 48'h0;
			crc_bad_q <= 1'b0;
		end
		else if (cmd_abort)
			st_q <= ST_IDLE;
		else if (cmd_task)
		begin
			task_q    <= mts_rx_task_e'(cmd_code);
			n_bytes_q <= tx_len(mts_tx_task_e'(cmd_code));
			sym_cnt_q <= 7'h00;
			fill_q    <= 5'h00;
			if (in_tx)
				st_q <= ST_TX_MOVE;
			else
			begin
				unique case (mts_rx_task_e'(cmd_code))
					RX_PREAMBLE_HUNT, RX_SYNC_HUNT:    st_q <= ST_HUNT;
					RX_HEADER_READ, RX_BODY_BLOCK_READ: st_q <= ST_BLOCK;
					RX_FOUR_SYMBOL:                     st_q <= ST_FOUR;
					default:                            st_q <= ST_ID;
				endcase
			end
		end
		else
		begin
			if (sym_in)
			begin
				win_q     <= win_d;
				sym_cnt_q <= sym_cnt_q + 7'h01;
				if (fill_q != `MTS_SYNC_LAST)
					fill_q <= fill_q + 5'h01;
			end
			unique case (st_q)
				ST_IDLE: ;
				ST_TX_MOVE: if (tx_fin) st_q <= ST_IDLE;
				ST_HUNT: if (sync_hit) st_q <= ST_HUNT_S;
				ST_HUNT_S:
					if (hunt_s)
					begin
						st_q      <= (task_q == RX_SYNC_HUNT) ? ST_IDLE : ST_ID;
						sym_cnt_q <= 7'h00;
					end
				ST_ID:
					if (id_bad)
					begin
						st_q   <= ST_HUNT;
						fill_q <= 5'h00;
					end
					else if (id_last)
					begin
						st_q      <= ST_ID_S;
						crc_bad_q <= !rx_dec.check_ok;
					end
				ST_ID_S: if (id_s) st_q <= ST_IDLE;
				ST_BLOCK: if (blk_end) st_q <= ST_IDLE;
				ST_FOUR: if (four_end) st_q <= ST_IDLE;
			endcase
		end
	end

	// data buffer, host pointers and transmit byte stream
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 12; i++)
				buf_q[i] <= 8'h00;
			wr_ptr_q  <= 4'h0;
			rd_ptr_q  <= 4'h0;
			dec_ptr_q <= 4'h0;
			move_q    <= 4'h0;
			four_q    <= 8'h00;
			tx_q      <= '0;
		end
		else
		begin
			if (dat_wr)
			begin
				buf_q[wr_ptr_q] <= axi_req.wdata[7:0];
				wr_ptr_q        <= ptr_inc(wr_ptr_q);
			end
			if (dat_rd)
				rd_ptr_q <= ptr_inc(rd_ptr_q);
			if (rx_dec.valid && (st_q == ST_ID || st_q == ST_BLOCK))
			begin
				buf_q[dec_ptr_q] <= rx_dec.data;
				dec_ptr_q        <= ptr_inc(dec_ptr_q);
			end
			if (st_q == ST_FOUR && sym_in)
				four_q <= {four_q[5:0], rx_sym.value};
			if (four_end)
				buf_q[0] <= {four_q[5:0], rx_sym.value};
			if (id_bad)
				dec_ptr_q <= 4'h0;
			if (tx_take)
				tx_q.valid <= 1'b0;
			if (tx_load)
			begin
				tx_q.valid <= 1'b1;
				tx_q.data  <= buf_q[move_q];
				move_q     <= move_q + 4'h1;
			end
			if (cmd_fire && cmd_code != RX_NOP)
			begin
				wr_ptr_q  <= 4'h0;
				rd_ptr_q  <= 4'h0;
				dec_ptr_q <= 4'h0;
				move_q    <= 4'h0;
			end
			if (cmd_abort)
				tx_q.valid <= 1'b0;
		end
	end

	// pin driven from the flag one cycle later
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			attn_n_q <= 1'b1;
		else
			attn_n_q <= !(irq_q && mode_q[`MTS_MODE_PIN_EN]);
	end

	assign axi_rsp               = rsp_q;
	assign tx_out                = tx_q;
	assign attention_out_n       = attn_n_q;
	assign crc_init_ones         = crc_ones_q;
	assign symbol_timing_acquire = acq_t_q;
	assign level_acquire         = acq_l_q;
	assign acquire_abort         = abort_q;

	// checks on the sequencing
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_task_taken;
		cmd_task && !cmd_abort;
	endsequence

	a_task_clears_avail: assert property (s_task_taken |=> !avail_q)
		else $error("task accepted but buffer still available");
	a_cancel_no_irq: assert property (cmd_abort |=> avail_q && st_q == ST_IDLE && !$rose(irq_q))
		else $error("cancel did not idle cleanly");
	a_nop_stays_idle: assert property (cmd_fire && cmd_code == 3'b000 && st_q == ST_IDLE |=> st_q == ST_IDLE)
		else $error("no-op started a task");
	a_tx_done_flags: assert property (tx_fin |=> avail_q && irq_q ##1 !attention_out_n || !mode_q[1])
		else $error("transmit done flags missing");
	a_pin_follows: assert property (!irq_q |=> attention_out_n)
		else $error("attention pin low without flag");
	a_third_s_done: assert property (blk_end |=> avail_q && sym_rdy_q && st_q == ST_IDLE)
		else $error("third status symbol not with done");
	a_ss_irq: assert property (ev_status_symbol_value && ss_ien |=> irq_q && status_symbol_value_q == $past(rx_sym.value))
		else $error("status symbol not captured");
	a_id_bad_resume: assert property (id_bad |=> st_q == ST_HUNT && fill_q == 5'h00)
		else $error("bad station id did not resume hunt");
	a_block_crc: assert property (blk_end |=> crc_fail_q == !$past(rx_dec.check_ok))
		else $error("checksum flag wrong after block");

endmodule

// ===== testbench/mts_link_model.sv
// Purpose: far side model, interleave sink and symbol and decoder source
// Assumes: same clock as the sequencer
// Notes:   hold stalls the sink, slow makes the sink ready one cycle in four
`timescale 1ns/100ps
module mts_link_model (
	// clock
	input  wire logic            clock,
	// sink pacing
	input  wire logic            hold,
	input  wire logic            slow,
	// streams
	input  wire mts_pkg::mts_tx_s tx_out,
	output logic                 tx_ready,
	output mts_pkg::mts_sym_s    rx_sym,
	output mts_pkg::mts_dec_s    rx_dec
);
	import mts_pkg::*;
	mts_byte_t  got[$];
	logic [1:0] cnt = 2'h0;

	// lines start quiet
	initial
	begin
		tx_ready = 1'b0;
		rx_sym = '0;
		rx_dec = '0;
	end

	// a stalled sink makes the sequencer defer its byte moves
	always @(posedge clock)
	begin
		cnt <= cnt + 2'h1;
		tx_ready <= !hold && (!slow || cnt == 2'h0);
		if (tx_out.valid === 1'b1 && tx_ready)
			got.push_back(tx_out.data);
	end

	// one symbol; the value line is scrambled between symbols
	task automatic sym(input logic [1:0] v);
		@(posedge clock);
		rx_sym <= {1'b1, v};
		@(posedge clock);
		rx_sym <= {1'b0, ~v};
	endtask

	// one decoded byte; the verdict stays as a level
	task automatic dec(input mts_byte_t b, input logic ok);
		@(posedge clock);
		rx_dec <= {1'b1, b, ok};
		@(posedge clock);
		rx_dec <= {1'b0, ~b, ok};
	endtask
endmodule

// ===== testbench/tb_top.sv
// Purpose: self-checking bench of the task sequencer
// Assumes: register map and latencies as handed over
// Notes:   data from a fixed xorshift seed, corner cases by hand
`timescale 1ns/100ps
module tb_top;
	import mts_pkg::*;
	localparam logic [31:0] a_cmd = 32'h0;
	localparam logic [31:0] a_dat = 32'h4;
	localparam logic [31:0] a_st  = 32'h8;
	localparam logic [47:0] sync_pat = 48'h223749F25B1B;
	logic         clock;
	logic         arst_n;
	mts_axi_req_s req;
	mts_axi_rsp_s rsp;
	mts_sym_s     rx_sym;
	mts_dec_s     rx_dec;
	mts_tx_s      tx_out;
	logic         tx_ready, hold, slow, pin_n, header_checksum, tim, lev, abrt;
	int           failures, n_checks, n_tim, n_lev, n_abrt;
	int           lens[8] = '{0, 6, 10, 12, 8, 1, 3, 0};
	logic [31:0]  seed = 32'hD758A394;
	logic [31:0]  d;
	logic [1:0]   r, sv;
	mts_byte_t    buf_q[$];

	mts_sequencer DUT (.clock(clock), .arst_n(arst_n), .axi_req(req), .axi_rsp(rsp),
		.rx_sym(rx_sym), .rx_dec(rx_dec), .tx_out(tx_out), .tx_ready(tx_ready),
		.attention_out_n(pin_n), .crc_init_ones(header_checksum), .symbol_timing_acquire(tim),
		.level_acquire(lev), .acquire_abort(abrt));
	mts_link_model LNK (.clock(clock), .hold(hold), .slow(slow), .tx_out(tx_out),
		.tx_ready(tx_ready), .rx_sym(rx_sym), .rx_dec(rx_dec));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// pulse counters, pulses last one cycle so counting edges is exact
	always @(posedge clock)
	begin
		n_tim <= n_tim + int'(tim === 1'b1);
		n_lev <= n_lev + int'(lev === 1'b1);
		n_abrt <= n_abrt + int'(abrt === 1'b1);
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// a 24-symbol sync pattern, first symbol first; symbol number bad goes out inverted
	task automatic send_sync(input int bad);
		for (int i = 0; i < 24; i++)
			LNK.sym(sync_pat[46 - 2*i +: 2] ^ ((i == bad) ? 2'h3 : 2'h0));
	endtask

	// each channel released at the edge that takes it; bready stays high
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		logic ta, tw;
		@(posedge clock);
		req.awaddr <= a;
		req.wdata <= v;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		repeat (99)
		begin
			@(negedge clock);
			if (rsp.bvalid === 1'b1)
				break;
			ta = rsp.awready === 1'b1;
			tw = rsp.wready === 1'b1;
			@(posedge clock);
			if (ta)
				req.awvalid <= 1'b0;
			if (tw)
				req.wvalid <= 1'b0;
		end
		r = rsp.bresp;
	endtask

	task automatic rd(input logic [31:0] a);
		logic ta;
		@(posedge clock);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		repeat (99)
		begin
			@(negedge clock);
			if (rsp.rvalid === 1'b1)
				break;
			ta = rsp.arready === 1'b1;
			@(posedge clock);
			if (ta)
				req.arvalid <= 1'b0;
		end
		d = rsp.rdata;
		r = rsp.rresp;
	endtask

	task automatic rdc(input string nm, input logic [31:0] a, e, m = 32'hFF);
		rd(a);
		chk(nm, e, d & m);
	endtask

	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// the run needs some 1.1k cycles
	initial
	begin
		repeat (60000) @(posedge clock);
		failures++;
		results();
	end

	initial
	begin
		req = '0;
		req.wstrb = 4'hF;
		req.bready = 1'b1;
		req.rready = 1'b1;
		{hold, slow} = 2'h0;
		arst_n = 1'b0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		rdc("status", a_st, 32'h01);
		rdc("mode", 32'hC, 32'h00);
		rdc("command", a_cmd, 32'h00);
		rd(32'h10);
		chk("unmapped rd", 32'h2, r);
		wr(32'h12, 32'h1);
		chk("unmapped wr", 32'h2, r);
		$display("test map done");
		wr(a_cmd, 32'hE0);
		repeat (2) @(posedge clock);
		chk("timing pulse", 1, n_tim);
		chk("level pulse", 1, n_lev);
		chk("crc ones", 0, header_checksum);
		rdc("nop idle", a_st, 1, 1);
		wr(a_cmd, 32'h0);
		chk("crc ones", 1, header_checksum);
		$display("test nop done");
		// transmit, each task starts on a stalled sink, slow and full-speed sinks alternate
		wr(32'hC, 32'h3);
		for (int c = 1; c < 7; c++)
		begin
			@(posedge clock);
			slow <= c[0];
			hold <= 1'b1;
			buf_q = {};
			LNK.got = {};
			for (int i = 0; i < lens[c]; i++)
			begin
				d = xs();
				buf_q.push_back(d[7:0]);
				wr(a_dat, {24'h0, d[7:0]});
			end
			wr(a_cmd, c);
			rdc("tx busy", a_st, 0, 1);
			@(posedge clock);
			hold <= 1'b0;
			for (int k = 0; k < 400 && LNK.got.size() < lens[c]; k++)
				@(posedge clock);
			repeat (3) @(negedge clock);
			chk("tx count", lens[c], LNK.got.size());
			for (int i = 0; i < lens[c]; i++)
				chk("tx byte", buf_q[i], LNK.got[i]);
			chk("pin low", 0, pin_n);
			rdc("tx done", a_st, 3, 3);
			repeat (2) @(negedge clock);
			chk("pin high", 1, pin_n);
		end
		$display("test tx done");
		wr(32'hC, 32'h4);
		wr(a_cmd, 32'h4);
		send_sync(24);
		d = xs();
		sv = d[1:0];
		LNK.sym(sv);
		rdc("sync done", a_st, {sv, 4'h7}, 32'h37);
		$display("test sync done");
		// preamble hunt: a bad station id resumes the hunt, then a sync with one error
		wr(32'hC, 32'hC);
		wr(a_cmd, 32'h1);
		for (int a = 0; a < 2; a++)
		begin
			send_sync(a ? 10 : 24);
			d = xs();
			sv = d[1:0];
			LNK.sym(sv);
			rdc("hunt status", a_st, {sv, 4'h6}, 32'h37);
			buf_q = {};
			for (int i = 0; i < 22; i++)
			begin
				if (i == 21)
				begin
					for (int j = 0; j < 3; j++)
					begin
						d = xs();
						buf_q.push_back(d[7:0]);
						LNK.dec(d[7:0], a[0]);
					end
				end
				LNK.sym(2'h0);
			end
			if (a == 0)
				rdc("id bad busy", a_st, 0, 1);
		end
		d = xs();
		sv = d[1:0];
		LNK.sym(sv);
		rdc("preamble done", a_st, {sv, 4'h7}, 32'h3F);
		for (int j = 0; j < 3; j++)
			rdc("id byte", a_dat, buf_q[j]);
		// four symbols read, first symbol lands in the top bits
		wr(a_cmd, 32'h5);
		d = xs();
		buf_q = {d[7:0]};
		for (int i = 6; i >= 0; i -= 2)
			LNK.sym(d[i +: 2]);
		rdc("four done", a_st, 3, 3);
		rdc("four byte", a_dat, buf_q[0]);
		$display("test preamble done");
		// header then body read; the verdict differs between them
		wr(32'hC, 32'h2);
		for (int c = 2; c < 4; c++)
		begin
			LNK.got = {};
			wr(a_cmd, c);
			rdc("rx busy", a_st, 0, 1);
			for (int i = 0; i < 69; i++)
			begin
				d = xs();
				sv = d[1:0];
				if (i == 68)
				begin
					buf_q = {};
					for (int j = 0; j < 12; j++)
					begin
						d = xs();
						buf_q.push_back(d[7:0]);
						LNK.dec(d[7:0], c[0]);
					end
				end
				LNK.sym(sv);
				if (i == 22)
					rdc("status sym", a_st, {sv, 4'h4}, 32'h37);
			end
			repeat (2) @(negedge clock);
			chk("rx pin low", 0, pin_n);
			rdc("rx done", a_st, {sv, ~c[0], 3'h7}, 32'h3F);
			for (int j = 0; j < 12; j++)
				rdc("rx byte", a_dat, buf_q[j]);
			chk("rx no tx", 0, LNK.got.size());
		end
		$display("test blocks done");
		wr(a_cmd, 32'h2);
		LNK.sym(2'h1);
		wr(a_cmd, 32'h7);
		repeat (2) @(negedge clock);
		rdc("cancel", a_st, 1, 3);
		chk("abort pulse", 1, n_abrt);
		$display("test cancel done");
		results();
	end
endmodule
